/* core/decode_pkg.sv */
// Constants, field layout and carriers for the instruction decoder.
// Assumes one oscillator clock; the decoder and phase divider import this package.
// Summary of operation
// [RL1] Most instructions are one 16-bit word
// [RL2] Two- and three-word instructions collect all words first
// [RL3] Single word splits into opcode and operands
// [RL4] Byte ops decode file, destination, access select
// [RL5] Destination zero writes the working accumulator
// [RL6] Destination one writes the addressed file register
// [RL7] Bit ops decode file, bit number, access select
// [RL8] Literal ops decode immediate, pointer select, or nothing
// [RL9] Control ops decode target, call mode, table mode
// [RL10] Continuation words carry four leading ones
// [RL11] Lone continuation word executes as no-operation
// [RL12] Plain single-word instruction takes one cycle
// [RL13] Taken test or jump adds one no-op cycle
// [RL14] Double-word instructions take two cycles
// [RL15] Instruction cycle is four oscillator periods
// [RL16] Taken two-word branch takes three cycles
// [RL17] Undefined opcode decodes as no-operation
package decode_pkg;

   // Timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned OSC_PER_CYCLE = 4;
   localparam logic [1:0] PHASE_FIRST = 2'h0;

   // Word layout
   localparam int unsigned WORD_W = 16;
   localparam int unsigned NIB_LSB = 12;
   localparam int unsigned NIB_W = 4;
   localparam int unsigned OPC_LSB = 10;
   localparam int unsigned OPC_W = 6;
   localparam int unsigned DEST_POS = 9;
   localparam int unsigned ACC_POS = 8;
   localparam int unsigned FILE_LSB = 0;
   localparam int unsigned FILE_W = 8;
   localparam int unsigned BIT_LSB = 9;
   localparam int unsigned BIT_W = 3;
   localparam int unsigned SUB_LSB = 8;
   localparam int unsigned SUB_W = 4;
   localparam int unsigned PTR_LSB = 4;
   localparam int unsigned PTR_W = 2;
   localparam int unsigned REL_W = 11;
   localparam int unsigned EXT_W = 12;
   localparam int unsigned MODE_POS = 0;
   localparam int unsigned TBL_W = 2;

   // Leading nibble classes
   localparam logic [3:0] NIB_CTRL = 4'h0;
   localparam logic [3:0] NIB_BYTE_LO = 4'h1;
   localparam logic [3:0] NIB_BYTE_HI = 4'h7;
   localparam logic [3:0] NIB_BIT_LO = 4'h8;
   localparam logic [3:0] NIB_BIT_SKIP = 4'hb;
   localparam logic [3:0] NIB_LIT = 4'hc;
   localparam logic [3:0] NIB_BRA = 4'hd;
   localparam logic [3:0] NIB_MULTI = 4'he;
   localparam logic [3:0] NIB_CONT = 4'hf;
   localparam logic [5:0] OPC_CMP_SKIP = 6'h08;

   // Control sub-codes
   localparam logic [3:0] SUB_NOP = 4'h0;
   localparam logic [3:0] SUB_RETURN = 4'h1;
   localparam logic [3:0] SUB_TABLE = 4'h2;
   // Multi-word sub-codes
   localparam logic [3:0] SUB_LOAD_PTR = 4'h0;
   localparam logic [3:0] SUB_CALL = 4'h1;
   localparam logic [3:0] SUB_GOTO = 4'h2;
   localparam logic [3:0] SUB_MOVE2 = 4'h3;
   localparam logic [3:0] SUB_MOVE3 = 4'h4;
   localparam logic [3:0] SUB_STORE3 = 4'h5;

   localparam logic [1:0] WORDS_ONE = 2'h1;
   localparam logic [1:0] WORDS_TWO = 2'h2;
   localparam logic [1:0] WORDS_THREE = 2'h3;

   typedef enum logic [2:0] {CLS_NOP, CLS_BYTE, CLS_BIT, CLS_LIT, CLS_CTRL, CLS_MULTI} cls_t;
   typedef enum logic [1:0] {ST_FIRST, ST_MORE, ST_FLUSH, ST_COND} state_t;

   // Decoded instruction handed to the execute side
   typedef struct packed {
      cls_t cls;
      logic [3:0] sub;
      logic [5:0] opcode;
      logic [7:0] file_addr;
      logic dest_file;
      logic wr_accum;
      logic access_sel;
      logic [2:0] bit_num;
      logic [7:0] literal;
      logic [1:0] ptr_sel;
      logic call_mode;
      logic [1:0] table_mode;
      logic [10:0] rel_target;
      logic [11:0] ext1;
      logic [11:0] ext2;
   } dec_t;

   // Sequencing needs of a first word
   typedef struct packed {
      logic [1:0] words;
      logic cond;
      logic branch;
   } info_t;

   function automatic logic [3:0] nib_of(input logic [15:0] w);
      return w[NIB_LSB +: NIB_W];
   endfunction

   function automatic logic [3:0] sub_of(input logic [15:0] w);
      return w[SUB_LSB +: SUB_W];
   endfunction

   function automatic logic is_byte(input logic [15:0] w);
      return (nib_of(w) >= NIB_BYTE_LO) && (nib_of(w) <= NIB_BYTE_HI);
   endfunction

   function automatic logic is_bit(input logic [15:0] w);
      return (nib_of(w) >= NIB_BIT_LO) && (nib_of(w) <= NIB_BIT_SKIP);
   endfunction

endpackage

/* core/cycle_phase.sv */
// Four-phase instruction cycle divider.
// Assumes clk is the oscillator; cyc_end_q marks the last phase of each cycle.
`timescale 1ns/100ps
`default_nettype none
module cycle_phase #(
   parameter int unsigned PHASES = decode_pkg::OSC_PER_CYCLE
) (
   input wire logic clk,
   input wire logic rst,
   output logic [1:0] phase_q,
   output logic cyc_end_q
);
   import decode_pkg::*;

   localparam logic [1:0] LAST = 2'(PHASES - 1);
   logic [1:0] phase_d;
   logic cyc_end_d;

   // Phase advance, wrap after the last oscillator period
   always_comb begin
      phase_d = (phase_q == LAST) ? PHASE_FIRST : phase_q + 2'h1; // see [RL15]
      cyc_end_d = (phase_d == LAST);
   end

   // Phase registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_q <= PHASE_FIRST;
         cyc_end_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         cyc_end_q <= cyc_end_d;
      end
   end
endmodule // cycle_phase
`default_nettype wire

/* core/instr_decode.sv */
// Instruction word decoder and instruction cycle sequencer.
// Assumes program memory holds prog_word steady at the last phase; execute side
// reports cond_true during the cycle after a conditional instruction issues.
`timescale 1ns/100ps
`default_nettype none
module instr_decode (
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] prog_word,
   input wire logic cond_true,
   output logic [1:0] phase_q,
   output logic cyc_end_q,
   output logic issue_q,
   output decode_pkg::dec_t dec_q,
   output logic nop_cycle_q
);
   import decode_pkg::*;

   state_t st_q, st_d;
   logic [1:0] left_q, left_d;
   logic [15:0] first_q, first_d;
   logic [11:0] ext1_q, ext1_d;
   logic issue_d, nop_cycle_d;
   dec_t dec_d;
   info_t info;
   info_t first_info;
   logic take_first;
   logic [3:0] nib;

   cycle_phase #(.PHASES(OSC_PER_CYCLE)) u_phase (
      .clk(clk),
      .rst(rst),
      .phase_q(phase_q),
      .cyc_end_q(cyc_end_q)
   );

   // Word count and timing class of a first word
   function automatic info_t classify(input logic [15:0] w);
      info_t r;
      r = '{words: WORDS_ONE, cond: 1'b0, branch: 1'b0}; // see [RL1]
      if (nib_of(w) == NIB_BRA) begin
         r.branch = 1'b1;
      end else if (nib_of(w) == NIB_CTRL && sub_of(w) == SUB_RETURN) begin
         r.branch = 1'b1;
      end else if (nib_of(w) == NIB_BIT_SKIP) begin
         r.cond = 1'b1;
      end else if (is_byte(w) && w[OPC_LSB +: OPC_W] == OPC_CMP_SKIP) begin
         r.cond = 1'b1;
      end else if (nib_of(w) == NIB_MULTI) begin // see [RL2]
         case (sub_of(w))
            SUB_LOAD_PTR, SUB_MOVE2: r.words = WORDS_TWO;
            SUB_CALL, SUB_GOTO: begin
               r.words = WORDS_TWO;
               r.branch = 1'b1; // see [RL16]
            end
            SUB_MOVE3, SUB_STORE3: r.words = WORDS_THREE;
            default: r.words = WORDS_ONE; // see [RL17]
         endcase
      end
      return r;
   endfunction

   // Split the first word into opcode and operand fields
   function automatic dec_t decode(input logic [15:0] w);
      dec_t r;
      info_t ci;
      r = '0;
      ci = classify(w);
      r.cls = CLS_NOP;
      r.opcode = w[OPC_LSB +: OPC_W]; // see [RL3]
      r.sub = sub_of(w);
      if (is_byte(w)) begin
         r.cls = CLS_BYTE;
         r.file_addr = w[FILE_LSB +: FILE_W]; // see [RL4]
         r.dest_file = w[DEST_POS];
         r.wr_accum = ~w[DEST_POS]; // see [RL5] see [RL6]
         r.access_sel = w[ACC_POS];
      end else if (is_bit(w)) begin
         r.cls = CLS_BIT;
         r.file_addr = w[FILE_LSB +: FILE_W]; // see [RL7]
         r.bit_num = w[BIT_LSB +: BIT_W];
         r.access_sel = w[ACC_POS];
      end else if (nib_of(w) == NIB_LIT) begin
         r.cls = CLS_LIT;
         r.literal = w[FILE_LSB +: FILE_W]; // see [RL8]
         r.wr_accum = 1'b1;
      end else if (nib_of(w) == NIB_BRA) begin
         r.cls = CLS_CTRL;
         r.rel_target = w[FILE_LSB +: REL_W]; // see [RL9]
      end else if (nib_of(w) == NIB_CTRL) begin
         case (sub_of(w))
            SUB_RETURN: begin
               r.cls = CLS_CTRL;
               r.call_mode = w[MODE_POS];
            end
            SUB_TABLE: begin
               r.cls = CLS_CTRL;
               r.table_mode = w[MODE_POS +: TBL_W];
            end
            default: r.cls = CLS_NOP;
         endcase
      end else if (nib_of(w) == NIB_MULTI && ci.words != WORDS_ONE) begin
         r.cls = CLS_MULTI;
         r.literal = w[FILE_LSB +: FILE_W];
         r.ptr_sel = w[PTR_LSB +: PTR_W]; // see [RL8]
         r.call_mode = w[MODE_POS]; // see [RL9]
      end
      // Continuation and undefined words fall through as no-operation; see [RL11] see [RL17]
      return r;
   endfunction

   assign nib = nib_of(prog_word);
   assign info = classify(prog_word);
   // Timing class of the held first word of a multi-word instruction
   assign first_info = classify(first_q);
   assign take_first = (st_q == ST_FIRST) || (st_q == ST_COND && !cond_true);

   // Sequencer next state, evaluated only at the cycle's last phase
   always_comb begin
      st_d = st_q;
      left_d = left_q;
      first_d = first_q;
      ext1_d = ext1_q;
      issue_d = 1'b0;
      nop_cycle_d = 1'b0;
      dec_d = dec_q;
      if (cyc_end_q) begin
         if (take_first) begin
            if (info.words == WORDS_ONE) begin
               issue_d = 1'b1;
               dec_d = decode(prog_word);
               if (info.branch) begin
                  st_d = ST_FLUSH; // see [RL13]
               end else if (info.cond) begin
                  st_d = ST_COND;
               end else begin
                  st_d = ST_FIRST; // see [RL12]
               end
            end else begin
               first_d = prog_word;
               left_d = info.words - WORDS_ONE; // see [RL2]
               st_d = ST_MORE;
            end
         end else if (st_q == ST_MORE) begin
            // Extra words only supply their low bits; see [RL10]
            left_d = left_q - 2'h1;
            if (left_q == WORDS_TWO) begin
               ext1_d = prog_word[EXT_W-1:0];
            end else begin
               issue_d = 1'b1; // see [RL14]
               dec_d = decode(first_q);
               dec_d.ext1 = (first_info.words == WORDS_THREE) ? ext1_q : prog_word[EXT_W-1:0];
               dec_d.ext2 = (first_info.words == WORDS_THREE) ? prog_word[EXT_W-1:0] : 12'h000;
               st_d = first_info.branch ? ST_FLUSH : ST_FIRST; // see [RL16]
            end
         end else begin
            // Flushed or skipped word runs as a no-op cycle; see [RL13]
            nop_cycle_d = 1'b1;
            st_d = ST_FIRST;
         end
      end
   end

   // Sequencer registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_FIRST;
         left_q <= 2'h0;
         first_q <= 16'h0000;
         ext1_q <= 12'h000;
         issue_q <= 1'b0;
         nop_cycle_q <= 1'b0;
         dec_q <= '0;
      end else begin
         st_q <= st_d;
         left_q <= left_d;
         first_q <= first_d;
         ext1_q <= ext1_d;
         issue_q <= issue_d;
         nop_cycle_q <= nop_cycle_d;
         dec_q <= dec_d;
      end
   end

   // Cycle end recurs every four oscillator periods
   property p_cycle_len;
      @(posedge clk) disable iff (rst)
      cyc_end_q |=> !cyc_end_q [*3] ##1 cyc_end_q;
   endproperty
   a_cycle_len: assert property (p_cycle_len) else $error("cycle length not four"); // see [RL15]

   // Issue only in the first phase of a cycle
   property p_issue_phase;
      @(posedge clk) disable iff (rst)
      issue_q |-> phase_q == PHASE_FIRST && $past(cyc_end_q);
   endproperty
   a_issue_phase: assert property (p_issue_phase) else $error("issue off cycle boundary"); // see [RL3]

   // Lone continuation word issues as no-operation
   property p_cont_nop;
      @(posedge clk) disable iff (rst)
      cyc_end_q && st_q == ST_FIRST && nib == NIB_CONT |=> issue_q && dec_q.cls == CLS_NOP;
   endproperty
   a_cont_nop: assert property (p_cont_nop) else $error("continuation not a nop"); // see [RL11]

   // Byte destination bit picks accumulator or file
   property p_byte_dest;
      @(posedge clk) disable iff (rst)
      cyc_end_q && st_q == ST_FIRST && is_byte(prog_word)
         |=> dec_q.wr_accum == !$past(prog_word[DEST_POS]) && dec_q.file_addr == $past(prog_word[FILE_W-1:0]);
   endproperty
   a_byte_dest: assert property (p_byte_dest) else $error("byte destination wrong"); // see [RL5]

   // Literal instruction takes one cycle
   property p_single;
      @(posedge clk) disable iff (rst)
      cyc_end_q && st_q == ST_FIRST && nib == NIB_LIT |=> st_q == ST_FIRST ##4 !nop_cycle_q;
   endproperty
   a_single: assert property (p_single) else $error("single cycle stretched"); // see [RL12]

   // Single-word jump gets one flushed cycle
   property p_jump_flush;
      @(posedge clk) disable iff (rst)
      cyc_end_q && st_q == ST_FIRST && nib == NIB_BRA |=> st_q == ST_FLUSH ##4 nop_cycle_q;
   endproperty
   a_jump_flush: assert property (p_jump_flush) else $error("jump not flushed"); // see [RL13]

   // Two-word non-branch issues after its second word
   property p_two_word;
      @(posedge clk) disable iff (rst)
      cyc_end_q && st_q == ST_FIRST && nib == NIB_MULTI && sub_of(prog_word) == SUB_LOAD_PTR
         |=> !issue_q ##4 issue_q ##4 !nop_cycle_q;
   endproperty
   a_two_word: assert property (p_two_word) else $error("two-word timing wrong"); // see [RL14]

   // Two-word branch adds a flushed third cycle
   property p_long_branch;
      @(posedge clk) disable iff (rst)
      cyc_end_q && st_q == ST_FIRST && nib == NIB_MULTI && sub_of(prog_word) == SUB_GOTO
         |=> ##4 issue_q ##4 nop_cycle_q;
   endproperty
   a_long_branch: assert property (p_long_branch) else $error("long branch not three cycles"); // see [RL16]

   // Undefined multi-word sub-code issues as no-operation
   property p_undef;
      @(posedge clk) disable iff (rst)
      cyc_end_q && st_q == ST_FIRST && nib == NIB_MULTI && sub_of(prog_word) > SUB_STORE3
         |=> issue_q && dec_q.cls == CLS_NOP;
   endproperty
   a_undef: assert property (p_undef) else $error("undefined opcode not nop"); // see [RL17]

   // Skip taken turns next cycle into no-op
   property p_skip;
      @(posedge clk) disable iff (rst)
      cyc_end_q && st_q == ST_COND && cond_true |=> nop_cycle_q && !issue_q;
   endproperty
   a_skip: assert property (p_skip) else $error("skip not honoured"); // see [RL13]
endmodule // instr_decode
`default_nettype wire

/* test/prog_source.sv */
// Program memory fetch and execute-side test result model for the decoder.
// Assumes the bench fills mem and cond_mem while reset is high.
`timescale 1ns/100ps
`default_nettype none
module prog_source (
   input wire logic clk,
   input wire logic rst,
   input wire logic cyc_end,
   output logic [15:0] prog_word,
   output logic cond_true
);
   import decode_pkg::*;
   logic [15:0] mem [0:15];
   logic cond_mem [0:15];
   logic [3:0] pc_q;
   // One 16-bit word per instruction cycle, steady over the sampling edge
   always @(negedge clk or posedge rst) begin
      if (rst) begin
         pc_q <= 4'h0;
         prog_word <= 16'h0000;
         cond_true <= 1'b0;
      end else if (cyc_end) begin
         prog_word <= mem[pc_q];
         cond_true <= cond_mem[pc_q];
         pc_q <= pc_q + 4'h1;
      end else begin
         // Not sampled now, so show changing values
         prog_word <= ~prog_word;
         cond_true <= ~cond_true;
      end
   end
endmodule // prog_source
`default_nettype wire

/* test/mcu_core_instruction_decode_test.sv */
// Self-checking bench for the instruction decoder and cycle sequencer.
// Assumes prog_source supplies words; one outcome is logged per cycle.
`timescale 1ns/100ps
`default_nettype none
module mcu_core_instruction_decode_test;
   import decode_pkg::*;
   logic clk;
   logic rst;
   logic [15:0] prog_word;
   logic cond_true;
   logic [1:0] phase_q;
   logic cyc_end_q;
   logic issue_q;
   dec_t dec_q;
   logic nop_cycle_q;
   logic [1:0] ev [$];
   dec_t dq [$];
   int n_errors = 0;
   int checked = 0;

   instr_decode dut (.clk(clk), .rst(rst), .prog_word(prog_word), .cond_true(cond_true), .phase_q(phase_q),
      .cyc_end_q(cyc_end_q), .issue_q(issue_q), .dec_q(dec_q), .nop_cycle_q(nop_cycle_q));
   prog_source part (.clk(clk), .rst(rst), .cyc_end(cyc_end_q), .prog_word(prog_word), .cond_true(cond_true));

   // Clock
   initial begin
      clk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) clk = ~clk;
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Outcome log per cycle: 0 none, 1 issue, 2 no-op
   always @(negedge clk) begin
      if (!rst) begin
         chk("cyc_end_q", {15'h0, phase_q == 2'h3}, {15'h0, cyc_end_q});
         if (phase_q === PHASE_FIRST) begin
            ev.push_back(issue_q ? 2'h1 : (nop_cycle_q ? 2'h2 : 2'h0));
            dq.push_back(dec_q);
         end else
            chk("pulse_phase", 16'h0, {15'h0, issue_q | nop_cycle_q});
      end
   end

   task automatic put(input int i, input logic [15:0] w, input logic c);
      part.mem[i] = w;
      part.cond_mem[i] = c;
   endtask

   task automatic start();
      int i;
      @(negedge clk);
      rst <= 1'b1;
      for (i = 0; i < 16; i++)
         put(i, 16'hc000, 1'b0);
   endtask

   task automatic go(input int n);
      int k;
      repeat (20) @(negedge clk);
      ev.delete();
      dq.delete();
      rst <= 1'b0;
      for (k = 0; k < 8 * n && ev.size() < n; k++)
         @(negedge clk);
      chk("cycles", 16'(n), 16'(ev.size()));
   endtask

   // Expected outcomes packed two bits a cycle, cycle 0 lowest
   task automatic evs(input int n, input logic [31:0] exp);
      int k;
      for (k = 0; k < n; k++)
         chk("event", {14'h0, exp[2 * k +: 2]}, {14'h0, ev[k]});
   endtask

   task automatic t_single();
      start();
      put(0, 16'hc5a5, 1'b0);
      put(1, 16'h1234, 1'b0);
      put(2, 16'h1c34, 1'b0);
      put(3, 16'h8b21, 1'b0);
      put(4, 16'h0203, 1'b0);
      go(5);
      evs(5, 32'h0000_0155);
      chk("lit", 16'h00a5, 16'(dq[0].literal));
      chk("lit_acc", 16'h0001, 16'(dq[0].wr_accum));
      chk("byte_cls", 16'(CLS_BYTE), 16'(dq[1].cls));
      chk("opcode", 16'h0004, 16'(dq[1].opcode));
      chk("file", 16'h0034, 16'(dq[1].file_addr));
      chk("dest1", 16'h0004, 16'({dq[1].dest_file, dq[1].wr_accum, dq[1].access_sel}));
      chk("opcode2", 16'h0007, 16'(dq[2].opcode));
      chk("dest0", 16'h0001, 16'({dq[2].dest_file, dq[2].wr_accum}));
      chk("bit_cls", 16'(CLS_BIT), 16'(dq[3].cls));
      chk("bit", 16'h0b21, 16'({dq[3].bit_num, dq[3].access_sel, dq[3].file_addr}));
      chk("table", 16'h000b, 16'({dq[4].sub, dq[4].table_mode}));
      $display("test single done");
   endtask

   task automatic t_branch();
      start();
      put(0, 16'hd123, 1'b0);
      put(1, 16'hc0ff, 1'b0);
      put(2, 16'hc011, 1'b0);
      put(3, 16'h0101, 1'b0);
      put(4, 16'hc022, 1'b0);
      put(5, 16'hc033, 1'b0);
      go(6);
      evs(6, 32'h0000_0659);
      chk("rel", 16'h0123, 16'(dq[0].rel_target));
      chk("after", 16'h0011, 16'(dq[2].literal));
      chk("ret", 16'h0003, 16'({dq[3].sub, dq[3].call_mode}));
      $display("test branch done");
   endtask

   task automatic t_skip();
      start();
      put(0, 16'h2055, 1'b0);
      put(1, 16'hc0aa, 1'b1);
      put(2, 16'h2055, 1'b0);
      put(3, 16'hc0bb, 1'b0);
      put(4, 16'hc0cc, 1'b1);
      put(5, 16'hb000, 1'b0);
      put(6, 16'hc0dd, 1'b1);
      put(7, 16'hc0ee, 1'b0);
      go(8);
      evs(8, 32'h0000_6559);
      chk("kept", 16'h00bb, 16'(dq[3].literal));
      $display("test skip done");
   endtask

   task automatic t_multi();
      int k;
      start();
      put(0, 16'he012, 1'b0);
      put(1, 16'hf345, 1'b0);
      put(2, 16'he2ab, 1'b0);
      put(3, 16'hfabc, 1'b0);
      put(5, 16'he4aa, 1'b0);
      put(6, 16'hf111, 1'b0);
      put(7, 16'hf222, 1'b0);
      put(8, 16'hf777, 1'b0);
      put(9, 16'he9aa, 1'b0);
      put(10, 16'hc055, 1'b0);
      // Call with mode bit set, then its flushed slot at 13
      put(11, 16'he101, 1'b0);
      put(12, 16'hf456, 1'b0);
      go(14);
      evs(8, 32'h0000_4244);
      chk("ptr", 16'h1345, 16'({dq[1].ptr_sel, dq[1].ext1}));
      chk("ext2_none", 16'h0000, 16'(dq[1].ext2));
      chk("goto", 16'h2abc, 16'({dq[3].sub, dq[3].ext1}));
      chk("three", 16'h1114, 16'({dq[7].ext1, dq[7].sub}));
      chk("three_ext2", 16'h0222, 16'(dq[7].ext2));
      for (k = 8; k < 10; k++)
         chk("lone", 16'({2'h1, CLS_NOP}), 16'({ev[k], dq[k].cls}));
      chk("resume", 16'h0155, 16'({ev[10], dq[10].literal}));
      chk("call", 16'h00c3, 16'({ev[11], ev[12], ev[13], dq[12].sub, dq[12].call_mode}));
      chk("call_ext", 16'h0456, 16'(dq[12].ext1));
      $display("test multi done");
   endtask

   task automatic give_verdict();
      $display("checked %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Watchdog, well past the four scenarios
   initial begin
      #(CLK_PERIOD_NS * 4000);
      n_errors++;
      give_verdict();
   end

   initial begin
      rst = 1'b1;
      t_single();
      t_branch();
      t_skip();
      t_multi();
      give_verdict();
   end
endmodule // mcu_core_instruction_decode_test
`default_nettype wire
